// *** gpio_mux_asserts.sv ***
// port-level assertions for the pin function mux
`timescale 1ns/10ps
module gpio_mux_asserts (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_rx_switch_ctrl,
	input wire logic serial_data_out,
	input wire logic serial_data_drive,
	input wire logic interrupt_notify_n,
	input wire logic pin1_out,
	input wire logic pin1_oe,
	input wire logic pin2_out,
	input wire logic pin2_oe
);
	logic [7:0] c1, c2, next_c1, next_c2;
	logic [1:0] live, next_live;
	// shadow of both control registers, so pins can be judged from ports alone
	always_comb begin
		next_c1 = c1;
		next_c2 = c2;
		next_live = {live[0], 1'b1};
		if (reg_write && reg_addr == 8'h4f)
			next_c1 = reg_wdata;
		if (reg_write && reg_addr == 8'h50)
			next_c2 = reg_wdata;
	end
	// live delays judgement: pins stay low for the first edge after reset
	always_ff @(posedge core_clk) begin
		c1 <= reset ? 8'h06 : next_c1;
		c2 <= reset ? 8'h02 : next_c2;
		live <= reset ? 2'b00 : next_live;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_force_wins: assert property (live[1] && $past(c1[4] && !c1[6])
		|-> pin1_out == $past(c1[5]) && pin1_oe) else $error("forced level lost");
	a_force_no_invert: assert property (live[1] && $past(c2[4] && c2[7] && !c2[6])
		|-> pin2_out == $past(c2[5])) else $error("forced level inverted");
	a_open_drain_low: assert property (live[1] && $past(c1[6]) |-> !pin1_out)
		else $error("open drain drove high");
	a_select_low: assert property (live[1] && $past(c1[6:4] == 0 && c1[2:0] == 0)
		|-> pin1_out == $past(c1[7]) && pin1_oe) else $error("low code wrong");
	a_select_txrx: assert property (live[1] && $past(c2[6:4] == 0 && c2[2:0] == 1)
		|-> pin2_out == $past(tx_rx_switch_ctrl ^ c2[7])) else $error("tx rx wrong");
	a_serial_drive: assert property (live[1] && $past(c2[7:4] == 0 && c2[2:0] == 4)
		|-> pin2_oe == $past(serial_data_drive) && (!pin2_oe || pin2_out == $past(serial_data_out)))
		else $error("serial drive wrong");
	a_interrupt_out: assert property (live[1] && $past(c1[6:4] == 0 && c1[2:0] == 7)
		|-> pin1_out == $past(interrupt_notify_n ^ c1[7])) else $error("notify wrong");
	a_read_back: assert property ($past(reg_read && reg_addr == 8'h4f)
		|-> reg_rdata == $past(c1)) else $error("read back wrong");
endmodule : gpio_mux_asserts
bind gpio_pin_function_mux gpio_mux_asserts checks (.*);

// *** gpio_mux_defines.svh ***
// addresses, reset values, field positions and codes of the pin function mux
`ifndef GPIO_MUX_DEFINES_SVH
`define GPIO_MUX_DEFINES_SVH

// register bus widths
`define REG_ADDR_W 8
`define REG_DATA_W 8

// bank 0 register addresses
`define ADDR_MONITOR_CONTROL 8'h4d
`define ADDR_PIN1_CTRL 8'h4f
`define ADDR_PIN2_CTRL 8'h50

// reset values
`define RESET_MONITOR_CONTROL 8'h01
`define RESET_PIN1_CTRL 8'h06
`define RESET_PIN2_CTRL 8'h02

// answer to a read of an unmapped address, and the idle read data
`define READ_IDLE 8'h00

// pin control register field positions
`define BIT_OUTPUT_INVERT 7
`define BIT_OPEN_DRAIN 6
`define BIT_FORCED_LEVEL 5
`define BIT_FORCE_ENABLE 4
`define FIELD_FSEL_HI 2
`define FIELD_FSEL_LO 0

// monitor control field position
`define FIELD_MON_SRC_HI 3
`define FIELD_MON_SRC_LO 0

// function selector codes
`define FSEL_LOW 3'h0
`define FSEL_TX_RX_SWITCH 3'h1
`define FSEL_ANTENNA_SELECT 3'h2
`define FSEL_EXT_AMP 3'h3
`define FSEL_SERIAL_DATA 3'h4
`define FSEL_DATA_CLOCK 3'h5
`define FSEL_MONITOR 3'h6
`define FSEL_INTERRUPT 3'h7

// monitor source codes
`define MON_SRC_LOW 4'h0
`define MON_SRC_CLOCK_OUT 4'h1
`define MON_SRC_SYNTH_LOCK 4'h2
`define MON_SRC_SYNC_DETECT 4'h3

// number of pins and depth of the input synchroniser
`define PIN_COUNT 2
`define SYNC_DEPTH 3

`endif

// *** gpio_mux_pkg.sv ***
// types shared by the pin function mux files
package gpio_mux_pkg;

	// layout of one pin control register
	typedef struct packed {
		logic output_invert;
		logic open_drain;
		logic forced_level;
		logic force_enable;
		logic reserved;
		logic [2:0] function_select;
	} pin_ctrl_t;

	// internal signals a pin may carry
	typedef struct packed {
		logic tx_rx_switch_ctrl;
		logic antenna_select_ctrl;
		logic ext_amp_ctrl;
		logic serial_data_out;
		logic serial_data_drive;
		logic serial_data_clock;
		logic monitor_signal;
		logic interrupt_notify_n;
	} func_sources_t;

	// what a pin pad is told to do
	typedef struct packed {
		logic level;
		logic enable;
	} pin_drive_t;

endpackage : gpio_mux_pkg

// *** gpio_pin_function_mux.sv ***
// register file, monitor select and pin drive of the two function pins
`timescale 1ns/10ps
`include "gpio_mux_defines.svh"

// Overview of operation
// - Control bit 5 holds the forced level: 0 drives low, 1 drives high.
// - The polarity bit never alters the forced level on the pin.
// - Control bit 4 enables the forced output; 0 leaves the selected function.
// - Control bit 7 inverts the selected function output.
// - Control bit 6 selects open-drain drive instead of push-pull.
// - Selector 000 low, 001 tx/rx switch, 010 antenna select, 011 amplifier.
// - Selector 100 makes the pin serial data line, 101 the data clock.
// - Selector 110 gives the digital monitor, 111 the interrupt notification.
// - First pin control register at 0x4f, reset 0x06, monitor after reset.
// - Second pin control register at 0x50, reset 0x02, antenna select.
// - Monitor source: 0000 low, 0001 clock out, 0010 lock, 0011 sync.
module gpio_pin_function_mux
	import gpio_mux_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [`REG_ADDR_W-1:0] reg_addr,
	input wire logic [`REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`REG_DATA_W-1:0] reg_rdata,
	input wire logic tx_rx_switch_ctrl,
	input wire logic antenna_select_ctrl,
	input wire logic ext_amp_ctrl,
	input wire logic serial_data_out,
	input wire logic serial_data_drive,
	input wire logic serial_data_clock,
	input wire logic interrupt_notify_n,
	input wire logic clock_out,
	input wire logic synth_locked,
	input wire logic sync_detected,
	input wire logic pin1_in,
	input wire logic pin2_in,
	output logic pin1_out,
	output logic pin1_oe,
	output logic pin2_out,
	output logic pin2_oe,
	output logic serial_data_line_in,
	output logic monitor_signal
);

	// register state
	pin_ctrl_t pin1_function_control;
	pin_ctrl_t pin2_function_control;
	logic [`REG_DATA_W-1:0] monitor_control;
	logic [`REG_DATA_W-1:0] next_reg_rdata;
	pin_ctrl_t next_pin1_function_control;
	pin_ctrl_t next_pin2_function_control;
	logic [`REG_DATA_W-1:0] next_monitor_control;

	// monitor and pin state
	logic [`FIELD_MON_SRC_HI-`FIELD_MON_SRC_LO:0] monitor_source_select;
	logic next_monitor_signal;
	func_sources_t sources;
	pin_drive_t pin1_drive;
	pin_drive_t pin2_drive;
	logic pin1_input_mode;
	logic pin2_input_mode;

	// input synchronisers, one chain per pin
	logic [`SYNC_DEPTH-1:0] pin_sync [`PIN_COUNT];
	logic [`SYNC_DEPTH-1:0] next_pin_sync [`PIN_COUNT];
	logic [`PIN_COUNT-1:0] pin_settled;
	logic [`PIN_COUNT-1:0] next_pin_settled;
	logic next_serial_data_line_in;

	// register writes and the one-cycle read answer
	always_comb begin
		next_pin1_function_control = pin1_function_control;
		next_pin2_function_control = pin2_function_control;
		next_monitor_control = monitor_control;
		next_reg_rdata = `READ_IDLE;
		if (reg_write) begin
			case (reg_addr)
				`ADDR_PIN1_CTRL: next_pin1_function_control = pin_ctrl_t'(reg_wdata);
				`ADDR_PIN2_CTRL: next_pin2_function_control = pin_ctrl_t'(reg_wdata);
				`ADDR_MONITOR_CONTROL: next_monitor_control = reg_wdata;
				default: next_monitor_control = monitor_control;
			endcase
		end
		// read data stands for exactly the cycle after the strobe
		if (reg_read) begin
			case (reg_addr)
				`ADDR_PIN1_CTRL: next_reg_rdata = pin1_function_control;
				`ADDR_PIN2_CTRL: next_reg_rdata = pin2_function_control;
				`ADDR_MONITOR_CONTROL: next_reg_rdata = monitor_control;
				default: next_reg_rdata = `READ_IDLE;
			endcase
		end
	end

	// register file flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin1_function_control <= pin_ctrl_t'(`RESET_PIN1_CTRL);
			pin2_function_control <= pin_ctrl_t'(`RESET_PIN2_CTRL);
			monitor_control <= `RESET_MONITOR_CONTROL;
			reg_rdata <= `READ_IDLE;
		end else begin
			pin1_function_control <= next_pin1_function_control;
			pin2_function_control <= next_pin2_function_control;
			monitor_control <= next_monitor_control;
			reg_rdata <= next_reg_rdata;
		end
	end

	assign monitor_source_select = monitor_control[`FIELD_MON_SRC_HI:`FIELD_MON_SRC_LO];

	// digital monitor source; unused codes read as low
	always_comb begin
		case (monitor_source_select)
			`MON_SRC_LOW: next_monitor_signal = 1'b0;
			`MON_SRC_CLOCK_OUT: next_monitor_signal = clock_out;
			`MON_SRC_SYNTH_LOCK: next_monitor_signal = synth_locked;
			`MON_SRC_SYNC_DETECT: next_monitor_signal = sync_detected;
			default: next_monitor_signal = 1'b0;
		endcase
	end

	// registered monitor feeds both pins, adding one cycle of delay
	always_ff @(posedge core_clk) begin
		if (reset) begin
			monitor_signal <= 1'b0;
		end else begin
			monitor_signal <= next_monitor_signal;
		end
	end

	// bundle of signals offered to each pin
	always_comb begin
		sources.tx_rx_switch_ctrl = tx_rx_switch_ctrl;
		sources.antenna_select_ctrl = antenna_select_ctrl;
		sources.ext_amp_ctrl = ext_amp_ctrl;
		sources.serial_data_out = serial_data_out;
		sources.serial_data_drive = serial_data_drive;
		sources.serial_data_clock = serial_data_clock;
		sources.monitor_signal = monitor_signal;
		sources.interrupt_notify_n = interrupt_notify_n;
	end

	// first pin, reset to the monitor function
	pin_output_stage u_pin1_stage (
		.ctrl(pin1_function_control),
		.sources(sources),
		.next_drive(pin1_drive),
		.serial_input_mode(pin1_input_mode)
	);

	// second pin, reset to antenna select
	pin_output_stage u_pin2_stage (
		.ctrl(pin2_function_control),
		.sources(sources),
		.next_drive(pin2_drive),
		.serial_input_mode(pin2_input_mode)
	);

	// pad outputs come straight from flops; pins float during reset and drive their reset functions from the first edge after it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin1_out <= 1'b0;
			pin1_oe <= 1'b0;
			pin2_out <= 1'b0;
			pin2_oe <= 1'b0;
		end else begin
			pin1_out <= pin1_drive.level;
			pin1_oe <= pin1_drive.enable;
			pin2_out <= pin2_drive.level;
			pin2_oe <= pin2_drive.enable;
		end
	end

	// pin inputs are asynchronous: three stages, a change counts when the
	// second and third agree; the first stage feeds only the second
	always_comb begin
		next_pin_sync[0] = {pin_sync[0][`SYNC_DEPTH-2:0], pin1_in};
		next_pin_sync[1] = {pin_sync[1][`SYNC_DEPTH-2:0], pin2_in};
		next_pin_settled = pin_settled;
		for (int i = 0; i < `PIN_COUNT; i++) begin
			if (pin_sync[i][`SYNC_DEPTH-1] == pin_sync[i][`SYNC_DEPTH-2]) begin
				next_pin_settled[i] = pin_sync[i][`SYNC_DEPTH-1];
			end
		end
	end

	// received serial data: first pin in input mode has priority
	always_comb begin
		if (pin1_input_mode) begin
			next_serial_data_line_in = pin_settled[0];
		end else if (pin2_input_mode) begin
			next_serial_data_line_in = pin_settled[1];
		end else begin
			next_serial_data_line_in = 1'b0;
		end
	end

	// synchroniser and received data flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < `PIN_COUNT; i++) begin
				pin_sync[i] <= '0;
			end
			pin_settled <= '0;
			serial_data_line_in <= 1'b0;
		end else begin
			for (int i = 0; i < `PIN_COUNT; i++) begin
				pin_sync[i] <= next_pin_sync[i];
			end
			pin_settled <= next_pin_settled;
			serial_data_line_in <= next_serial_data_line_in;
		end
	end

endmodule : gpio_pin_function_mux

// *** pad_partner.sv ***
// board side of one pad: pull-up plus an optional host driver
`timescale 1ns/10ps
module pad_partner (
	input wire logic pad_out,
	input wire logic pad_oe,
	input wire logic host_en,
	input wire logic host_lvl,
	output logic pad_in
);
	// the pull-up wins only when nobody drives, so a released pad never keeps its level
	assign pad_in = pad_oe ? pad_out : (host_en ? host_lvl : 1'b1);
endmodule : pad_partner

// *** pin_output_stage.sv ***
// selection, inversion, override and drive style of one pin
`timescale 1ns/10ps
`include "gpio_mux_defines.svh"

module pin_output_stage
	import gpio_mux_pkg::*;
(
	input wire pin_ctrl_t ctrl,
	input wire func_sources_t sources,
	output pin_drive_t next_drive,
	output logic serial_input_mode
);

	logic func_level;
	logic func_drives;
	logic level;
	logic drives;

	// pick the function, then apply polarity, override and drive style
	always_comb begin
		func_level = 1'b0;
		func_drives = 1'b1;
		serial_input_mode = 1'b0;
		case (ctrl.function_select)
			`FSEL_LOW: func_level = 1'b0;
			`FSEL_TX_RX_SWITCH: func_level = sources.tx_rx_switch_ctrl;
			`FSEL_ANTENNA_SELECT: func_level = sources.antenna_select_ctrl;
			`FSEL_EXT_AMP: func_level = sources.ext_amp_ctrl;
			`FSEL_SERIAL_DATA: begin
				// bidirectional: the core decides the direction
				func_level = sources.serial_data_out;
				func_drives = sources.serial_data_drive;
				serial_input_mode = ~sources.serial_data_drive;
			end
			`FSEL_DATA_CLOCK: func_level = sources.serial_data_clock;
			`FSEL_MONITOR: func_level = sources.monitor_signal;
			`FSEL_INTERRUPT: func_level = sources.interrupt_notify_n;
			default: func_level = 1'b0;
		endcase
		// polarity acts on the function output only
		level = func_level ^ ctrl.output_invert;
		drives = func_drives;
		// override wins over the selector, and bypasses the polarity
		if (ctrl.force_enable) begin
			level = ctrl.forced_level;
			drives = 1'b1;
			serial_input_mode = 1'b0;
		end
		// open drain only ever pulls low; the high is left to the pull-up
		if (ctrl.open_drain) begin
			next_drive.level = 1'b0;
			next_drive.enable = drives & ~level;
		end else begin
			next_drive.level = level;
			next_drive.enable = drives;
		end
	end

endmodule : pin_output_stage

// *** testbench.sv ***
// self-checking bench for the pin function mux
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic tx_rx_switch_ctrl = 1'b0, antenna_select_ctrl = 1'b0, ext_amp_ctrl = 1'b0;
	logic serial_data_out = 1'b0, serial_data_drive = 1'b1, serial_data_clock = 1'b0;
	logic interrupt_notify_n = 1'b1, clock_out = 1'b0, synth_locked = 1'b0;
	logic sync_detected = 1'b0, host_en = 1'b0, host_lvl = 1'b0;
	logic pin1_in, pin2_in, pin1_out, pin1_oe, pin2_out, pin2_oe;
	logic serial_data_line_in, monitor_signal;
	int n_errors = 0, cmp_count = 0;
	always #5 core_clk = ~core_clk;
	gpio_pin_function_mux DUT (.*);
	pad_partner board1 (.pad_out(pin1_out), .pad_oe(pin1_oe), .host_en(host_en),
		.host_lvl(host_lvl), .pad_in(pin1_in));
	pad_partner board2 (.pad_out(pin2_out), .pad_oe(pin2_oe), .host_en(host_en),
		.host_lvl(host_lvl), .pad_in(pin2_in));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	// covers the write path (2 edges), monitor path and the 5-edge input path
	task settle;
		repeat (5) @(posedge core_clk);
		#1;
	endtask : settle
	task test_done;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		#1000000;
		n_errors++;
		test_done;
	end
	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rd(8'h4f, 8'h06);
		rd(8'h50, 8'h02);
		rd(8'h4d, 8'h01);
		wr(8'h51, 8'h5a);
		rd(8'h51, 8'h00);
		clock_out <= 1'b1;
		antenna_select_ctrl <= 1'b1;
		settle;
		chk({6'h00, pin1_out, pin2_out}, 8'h03);
		wr(8'h4d, 8'h02);
		// every selector code, plain and inverted; only the chosen source
		// carries the tested level, so a crossed route shows up
		for (int k = 0; k < 32; k++) begin
			tx_rx_switch_ctrl <= k[4] ^ (k[2:0] != 3'h1);
			antenna_select_ctrl <= k[4] ^ (k[2:0] != 3'h2);
			ext_amp_ctrl <= k[4] ^ (k[2:0] != 3'h3);
			serial_data_out <= k[4] ^ (k[2:0] != 3'h4);
			serial_data_clock <= k[4] ^ (k[2:0] != 3'h5);
			synth_locked <= k[4] ^ (k[2:0] != 3'h6);
			interrupt_notify_n <= k[4] ^ (k[2:0] != 3'h7);
			wr(8'h50, {k[3], 4'h0, k[2:0]});
			settle;
			chk({6'h00, pin2_out, pin2_oe}, {6'h00, (k[2:0] != 0 && k[4]) ^ k[3], 1'b1});
		end
		// forced level with inversion set and the source at the other level
		for (int k = 0; k < 2; k++) begin
			tx_rx_switch_ctrl <= !k[0];
			wr(8'h50, {2'b10, k[0], 5'h11});
			settle;
			chk({6'h00, pin2_out, pin2_oe}, {6'h00, k[0], 1'b1});
		end
		// open drain: low is driven, high releases to the pull-up
		for (int k = 0; k < 2; k++) begin
			tx_rx_switch_ctrl <= k[0];
			wr(8'h50, 8'h41);
			settle;
			chk({5'h00, pin2_out, pin2_oe, pin2_in}, {6'h00, !k[0], k[0]});
		end
		// monitor sources, up to one unused code that must stay low
		for (int k = 0; k < 10; k++) begin
			{clock_out, synth_locked, sync_detected} <= {3{k[0]}};
			wr(8'h4d, 8'(k >> 1));
			settle;
			chk({6'h00, monitor_signal, pin1_out}, {6'h00, {2{k[0] && k > 1 && k < 8}}});
		end
		// pin1 settings for the checker: low, notify, open drain, forced high
		for (int k = 0; k < 4; k++) begin
			wr(8'h4f, k[1] ? (k[0] ? 8'h30 : 8'h40) : {5'h00, {3{k[0]}}});
			settle;
		end
		chk({6'h00, pin1_out, pin1_oe}, 8'h03);
		// pin1 as serial input, driven from the board side
		serial_data_drive <= 1'b0;
		wr(8'h4f, 8'h04);
		rd(8'h4f, 8'h04);
		for (int k = 0; k < 2; k++) begin
			host_en <= 1'b1;
			host_lvl <= k[0];
			settle;
			chk({6'h00, pin1_oe, serial_data_line_in}, {7'h00, k[0]});
		end
		// pin2 as serial input once pin1 leaves that mode
		wr(8'h4f, 8'h06);
		wr(8'h50, 8'h04);
		for (int k = 0; k < 2; k++) begin
			host_lvl <= !k[0];
			settle;
			chk({6'h00, pin2_oe, serial_data_line_in}, {7'h00, !k[0]});
		end
		// reset in mid-run brings both control registers back
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rd(8'h4f, 8'h06);
		rd(8'h50, 8'h02);
		settle;
		chk({6'h00, pin1_oe, pin2_oe}, 8'h03);
		test_done;
	end
endmodule : testbench
